/* File: hdl/clock_ratio_generation.sv */
// Function
// - host strap picks host clock, else agent
// - host clock halved, strap picks sync output
// - each bus clock output has own enable
// - csb ratio is sync times divider times multiplier
// - system multiplier two through six
// - core multiplier one to three in halves
// - core clocked from system bus clock
// - multipliers come from low reset word
// - memory clock doubled optionally, halved outside
// - memory data at internal memory clock rate
// - local bus clock one or two times
// - external local bus clock half, quarter, eighth
// - units default full, off/full/half/third
// - unit ratios register programmable, pci full/off
// - multiplier codes 0010 to 0110, rest reserved
// - core ratio zero bypasses core multiplier
`timescale 1ns/1ns
`default_nettype none
module clock_ratio_generation (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic host_input_clock_i,
  input wire logic agent_clock_i,
  input wire logic host_mode_strap_i,
  input wire logic input_halving_strap_i,
  input wire logic [31:0] reset_config_word_low_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic primary_clock_o,
  output logic sync_clock_o,
  output logic [2:0] bus_clock_outputs_o,
  output logic csb_tick_o,
  output logic core_tick_o,
  output logic memory_bus_clock_o,
  output logic memory_bus_clock_n_o,
  output logic memory_data_tick_o,
  output logic [1:0] local_bus_clock_out_o,
  output logic [4:0] unit_clock_en_o,
  output logic [3:0] csb_ratio_o,
  output logic [2:0] core_halves_o,
  output logic core_bypass_o,
  output logic config_error_o
);

  //////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // A bit moves only once the second and third sync stages agree.
  function automatic logic [35:0] agree(input logic [35:0] a,
                                        input logic [35:0] b,
                                        input logic [35:0] held);
    return (a & b) | (held & (a ^ b));
  endfunction : agree

  // Reload value of a unit divider: full 0, half 1, third 2.
  function automatic logic [1:0] unit_lim(input logic [1:0] mode);
    return (mode == clock_ratio_pkg::UNIT_OFF) ? 2'h0 : mode - 2'h1;
  endfunction : unit_lim

  // Half period of the external local bus clock in local bus ticks, less one.
  function automatic logic [1:0] lb_half(input logic [3:0] div);
    logic [1:0] r;
    r = 2'h3;
    if (div == clock_ratio_pkg::LB_DIV2)
      r = 2'h0;
    else if (div == clock_ratio_pkg::LB_DIV4)
      r = 2'h1;
    return r;
  endfunction : lb_half

  // Register address decode.
  function automatic logic mapped(input logic [7:0] a);
    return a == clock_ratio_pkg::OCC_OFFSET ||
           a == clock_ratio_pkg::LBC_OFFSET ||
           a == clock_ratio_pkg::UCC_OFFSET ||
           a == clock_ratio_pkg::CFG_OFFSET;
  endfunction : mapped

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [35:0] raw; // All asynchronous pin inputs in one bundle.
  logic [35:0] s1_reg, s2_reg, s3_reg, filt_reg; // Sync stages, filter.
  logic [35:0] s1_next, s2_next, s3_next, filt_next;
  clock_ratio_pkg::reset_cfg_t pin_cfg; // Filtered strap view.
  logic host_f, agent_f; // Filtered clock pin levels.

  assign raw = {host_input_clock_i, agent_clock_i, host_mode_strap_i,
                input_halving_strap_i, reset_config_word_low_i};
  assign host_f = filt_reg[35];
  assign agent_f = filt_reg[34];
  assign pin_cfg = {filt_reg[33], filt_reg[32],
                    filt_reg[clock_ratio_pkg::LB_RATIO_POS],
                    filt_reg[clock_ratio_pkg::MEM_RATIO_POS],
                    filt_reg[clock_ratio_pkg::MULT_LSB +: 4],
                    filt_reg[clock_ratio_pkg::CORE_LSB +: 7]};

  // Three stages; only the second and third feed the filter.
  always_comb
  begin
    s1_next = raw;
    s2_next = s1_reg;
    s3_next = s2_reg;
    filt_next = agree(s2_reg, s3_reg, filt_reg);
  end

  // Sync registers.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_reg <= 36'h0;
      s2_reg <= 36'h0;
      s3_reg <= 36'h0;
      filt_reg <= 36'h0;
    end
    else
    begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      filt_reg <= filt_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reset configuration capture.

  typedef enum logic [1:0] {
    CFG_WAIT = 2'b00,
    CFG_LATCH = 2'b01,
    CFG_RUN = 2'b11
  } cfg_state_t;

  cfg_state_t state_reg, state_next; // Capture sequencer.
  logic [2:0] wait_reg, wait_next; // Settling counter.
  clock_ratio_pkg::reset_cfg_t cfg_reg, cfg_next; // Held straps.
  clock_ratio_pkg::ratio_t rat_reg, rat_next; // Decoded ratios.
  logic run; // Clocks run once configuration is held.
  logic [3:0] mult; // Shorthand for the filtered multiplier field.
  logic [6:0] cf; // Shorthand for the filtered core field.

  assign run = state_reg == CFG_RUN;
  assign mult = pin_cfg.sys_mult;
  assign cf = pin_cfg.core_field;

  // Straps are taken once after settling and then frozen.
  always_comb
  begin
    state_next = state_reg;
    wait_next = wait_reg;
    cfg_next = cfg_reg;
    rat_next = rat_reg;
    case (state_reg)
      CFG_WAIT:
      begin
        // Let the pin filters fill before trusting them.
        wait_next = wait_reg + 3'h1;
        if (wait_reg == clock_ratio_pkg::SYNC_WAIT)
          state_next = CFG_LATCH;
      end
      CFG_LATCH:
      begin
        cfg_next = pin_cfg;
        // Codes 2..6 valid, the rest reserved and flagged.
        rat_next.cfg_error = mult < 4'h2 || mult > 4'h6;
        // Ratio to the sync input doubles when the input was halved.
        rat_next.csb_ratio = pin_cfg.no_halving ? mult
                             : 4'(mult << 1);
        rat_next.core_bypass = cf[4:1] == 4'h0;
        rat_next.core_halves = 3'h2;
        if (cf[4:1] != 4'h0)
        begin
          // Core ratio in halves: field ratio twice plus half bit.
          rat_next.core_halves = 3'({cf[3:1], cf[0]});
          if (cf[6:5] == 2'h3 || cf[4:1] > 4'h3 ||
              (cf[4:1] == 4'h3 && cf[0]))
            rat_next.cfg_error = 1'b1;
        end
        state_next = CFG_RUN;
      end
      CFG_RUN:
        state_next = CFG_RUN;
      default:
        state_next = CFG_WAIT;
    endcase
  end

  // Capture registers.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= CFG_WAIT;
      wait_reg <= 3'h0;
      cfg_reg <= '0;
      rat_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      cfg_reg <= cfg_next;
      rat_reg <= rat_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register file over APB; one wait state on every access.

  logic [2:0] occ_reg, occ_next; // Bus clock output enables.
  logic [3:0] lbc_reg, lbc_next; // Local bus divider field.
  logic [9:0] ucc_reg, ucc_next; // Two mode bits per unit.
  logic ack_reg, ack_next;
  logic err_reg, err_next;
  logic [31:0] rd_reg, rd_next;
  logic acc; // Access phase.

  assign acc = psel_i && penable_i;

  // Answer in the second access cycle; writes land on that edge.
  always_comb
  begin
    occ_next = occ_reg;
    lbc_next = lbc_reg;
    ucc_next = ucc_reg;
    ack_next = 1'b0;
    err_next = err_reg;
    rd_next = rd_reg;
    if (acc && !ack_reg)
    begin
      ack_next = 1'b1;
      err_next = !mapped(paddr_i);
      rd_next = 32'h0;
      case (paddr_i)
        clock_ratio_pkg::OCC_OFFSET: rd_next = {29'h0, occ_reg};
        clock_ratio_pkg::LBC_OFFSET: rd_next = {28'h0, lbc_reg};
        clock_ratio_pkg::UCC_OFFSET: rd_next = {22'h0, ucc_reg};
        clock_ratio_pkg::CFG_OFFSET: rd_next = {8'h0, rat_reg, cfg_reg};
        default: rd_next = 32'h0;
      endcase
    end
    else if (acc && ack_reg && pwrite_i)
    begin
      // Status word is read only; writes to it are dropped.
      case (paddr_i)
        clock_ratio_pkg::OCC_OFFSET: occ_next = pwdata_i[2:0];
        clock_ratio_pkg::LBC_OFFSET: lbc_next = pwdata_i[3:0];
        clock_ratio_pkg::UCC_OFFSET:
        begin
          ucc_next = pwdata_i[9:0];
          // The PCI and DMA group knows only off or full.
          if (pwdata_i[9:8] != clock_ratio_pkg::UNIT_OFF)
            ucc_next[9:8] = clock_ratio_pkg::UNIT_FULL;
        end
        default: ucc_next = ucc_reg;
      endcase
    end
  end

  // Register file flops.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      occ_reg <= clock_ratio_pkg::OCC_RESET;
      lbc_reg <= clock_ratio_pkg::LBC_RESET;
      ucc_reg <= clock_ratio_pkg::UCC_RESET;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rd_reg <= 32'h0;
    end
    else
    begin
      occ_reg <= occ_next;
      lbc_reg <= lbc_next;
      ucc_reg <= ucc_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
      rd_reg <= rd_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Primary clock, PCI sync clock and its gated copies.

  logic prim_reg, prim_next;
  logic host_prev_reg, host_prev_next; // For host clock rise detect.
  logic half_reg, half_next; // Host clock divided by two.
  logic sync_reg, sync_next;
  logic [2:0] bus_reg, bus_next;

  // Host mode drives the sync clock; agent mode leaves it low.
  always_comb
  begin
    prim_next = cfg_reg.host_mode ? host_f : agent_f;
    host_prev_next = host_f;
    half_next = half_reg;
    if (run && cfg_reg.host_mode && host_f && !host_prev_reg)
      half_next = !half_reg;
    sync_next = 1'b0;
    if (run && cfg_reg.host_mode)
      sync_next = cfg_reg.no_halving ? host_f : half_reg;
    bus_next = {3{sync_reg}} & occ_reg;
    if (!run)
      prim_next = 1'b0;
  end

  // Sync clock flops.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prim_reg <= 1'b0;
      host_prev_reg <= 1'b0;
      half_reg <= 1'b0;
      sync_reg <= 1'b0;
      bus_reg <= 3'h0;
    end
    else
    begin
      prim_reg <= prim_next;
      host_prev_reg <= host_prev_next;
      half_reg <= half_next;
      sync_reg <= sync_next;
      bus_reg <= bus_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Derived clocks; the system clock stands for twice the csb rate.

  logic phase_reg, phase_next; // Csb tick on every second edge.
  logic csb_reg, csb_next;
  logic memclk_reg, memclk_next;
  logic memclk_n_reg, memclk_n_next; // Own flop for the complement pin.
  logic ddr_reg, ddr_next;
  logic lbout_reg, lbout_next;
  logic [1:0] lbcnt_reg, lbcnt_next;
  logic [1:0] lbhp_reg, lbhp_next; // Active local bus half period.
  logic [1:0] ucnt_reg [5];
  logic [1:0] ucnt_next [5];
  logic [1:0] umode_reg [5];
  logic [1:0] umode_next [5];
  logic [4:0] uen_reg, uen_next;
  logic csb_t, ddr_t, lbc_t; // Ticks of csb, memory and local bus.

  assign csb_t = run && phase_reg;
  assign ddr_t = run && (cfg_reg.mem_ratio || phase_reg);
  assign lbc_t = run && (cfg_reg.lb_ratio || phase_reg);

  // Unit dividers switch ratio only at a period boundary, the local bus divider at a half-period boundary; never mid-pulse.
  always_comb
  begin
    phase_next = run && !phase_reg;
    csb_next = csb_t;
    ddr_next = ddr_t;
    memclk_next = ddr_t ? !memclk_reg : memclk_reg;
    memclk_n_next = !memclk_next;
    lbout_next = lbout_reg;
    lbcnt_next = lbcnt_reg;
    lbhp_next = lbhp_reg;
    if (lbc_t)
    begin
      lbcnt_next = lbcnt_reg + 2'h1;
      if (lbcnt_reg == lbhp_reg)
      begin
        lbout_next = !lbout_reg;
        lbcnt_next = 2'h0;
        lbhp_next = lb_half(lbc_reg);
      end
    end
    uen_next = 5'h0;
    for (int i = 0; i < 5; i++)
    begin
      ucnt_next[i] = ucnt_reg[i];
      umode_next[i] = umode_reg[i];
      if (csb_t)
      begin
        if (ucnt_reg[i] == 2'h0)
        begin
          // New ratio taken at the start of a unit period.
          umode_next[i] = ucc_reg[2*i +: 2];
          uen_next[i] = ucc_reg[2*i +: 2] != clock_ratio_pkg::UNIT_OFF;
          ucnt_next[i] = (unit_lim(ucc_reg[2*i +: 2]) == 2'h0) ? 2'h0
                         : 2'h1;
        end
        else
          ucnt_next[i] = (ucnt_reg[i] == unit_lim(umode_reg[i])) ? 2'h0
                         : ucnt_reg[i] + 2'h1;
      end
    end
  end

  // Derived clock flops.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      phase_reg <= 1'b0;
      csb_reg <= 1'b0;
      memclk_reg <= 1'b0;
      memclk_n_reg <= 1'b1;
      ddr_reg <= 1'b0;
      lbout_reg <= 1'b0;
      lbcnt_reg <= 2'h0;
      lbhp_reg <= 2'h3;
      uen_reg <= 5'h0;
      for (int i = 0; i < 5; i++)
      begin
        ucnt_reg[i] <= 2'h0;
        umode_reg[i] <= 2'h1;
      end
    end
    else
    begin
      phase_reg <= phase_next;
      csb_reg <= csb_next;
      memclk_reg <= memclk_next;
      memclk_n_reg <= memclk_n_next;
      ddr_reg <= ddr_next;
      lbout_reg <= lbout_next;
      lbcnt_reg <= lbcnt_next;
      lbhp_reg <= lbhp_next;
      uen_reg <= uen_next;
      for (int i = 0; i < 5; i++)
      begin
        ucnt_reg[i] <= ucnt_next[i];
        umode_reg[i] <= umode_next[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops.

  assign prdata_o = rd_reg;
  assign pready_o = ack_reg;
  assign pslverr_o = err_reg;
  assign primary_clock_o = prim_reg;
  assign sync_clock_o = sync_reg;
  assign bus_clock_outputs_o = bus_reg;
  assign csb_tick_o = csb_reg;
  assign core_tick_o = csb_reg;
  assign memory_bus_clock_o = memclk_reg;
  assign memory_bus_clock_n_o = memclk_n_reg;
  assign memory_data_tick_o = ddr_reg;
  assign local_bus_clock_out_o = {2{lbout_reg}};
  assign unit_clock_en_o = uen_reg;
  assign csb_ratio_o = rat_reg.csb_ratio;
  assign core_halves_o = rat_reg.core_halves;
  assign core_bypass_o = rat_reg.core_bypass;
  assign config_error_o = rat_reg.cfg_error;

endmodule : clock_ratio_generation
`default_nettype wire

/* File: hdl/clock_ratio_pkg.sv */
`default_nettype none
// Shared constants and types of the clock ratio block.
package clock_ratio_pkg;
  // Counts of outputs and of unit clocks.
  localparam int NUM_BUS_OUT = 3;
  localparam int NUM_UNITS = 5;
  localparam int SYNC_W = 36;
  // Register byte offsets.
  localparam logic [7:0] OCC_OFFSET = 8'h00;
  localparam logic [7:0] LBC_OFFSET = 8'h04;
  localparam logic [7:0] UCC_OFFSET = 8'h08;
  localparam logic [7:0] CFG_OFFSET = 8'h0C;
  // Values after reset.
  localparam logic [2:0] OCC_RESET = 3'h7;
  localparam logic [3:0] LBC_RESET = 4'h8;
  localparam logic [9:0] UCC_RESET = 10'h155;
  // Local bus divider codes.
  localparam logic [3:0] LB_DIV2 = 4'h2;
  localparam logic [3:0] LB_DIV4 = 4'h4;
  // Field positions inside the low reset configuration word.
  localparam int LB_RATIO_POS = 0;
  localparam int MEM_RATIO_POS = 1;
  localparam int MULT_LSB = 4;
  localparam int CORE_LSB = 8;
  // Cycles from reset release until the strap filters hold valid data.
  localparam logic [2:0] SYNC_WAIT = 3'h4;
  // Per-unit clock mode encoding.
  typedef enum logic [1:0] {
    UNIT_OFF = 2'h0,
    UNIT_FULL = 2'h1,
    UNIT_HALF = 2'h2,
    UNIT_THIRD = 2'h3
  } unit_mode_t;
  // Reset-time configuration held until the next reset.
  typedef struct packed {
    logic host_mode;
    logic no_halving;
    logic lb_ratio;
    logic mem_ratio;
    logic [3:0] sys_mult;
    logic [6:0] core_field;
  } reset_cfg_t;
  // Decoded ratios shown in the status register.
  typedef struct packed {
    logic cfg_error;
    logic core_bypass;
    logic [2:0] core_halves;
    logic [3:0] csb_ratio;
  } ratio_t;
endpackage : clock_ratio_pkg
`default_nettype wire

/* File: dv/pci_clock_source.sv */
`timescale 1ns/1ns
`default_nettype none
// Far-side clock sources: the host oscillator and the agent bus clock.
module pci_clock_source #(
  parameter int HOST_HALF = 3,
  parameter int AGENT_HALF = 5
) (
  input wire logic sys_clk_i,
  input wire logic agent_mode_i,
  output logic host_clk_o,
  output logic agent_clk_o
);
  int hc = 0; // Host half-period counter.
  int ac = 0; // Agent half-period counter.
  logic hq = 1'h0; // Free-running host oscillator.
  logic aq = 1'h0; // Free-running agent bus clock.
  // Both rates stay well below the sampling clock so the filters see them.
  always @(posedge sys_clk_i)
  begin
    hc <= (hc == HOST_HALF - 1) ? 0 : hc + 1;
    ac <= (ac == AGENT_HALF - 1) ? 0 : ac + 1;
    if (hc == HOST_HALF - 1) hq <= ~hq;
    if (ac == AGENT_HALF - 1) aq <= ~aq;
  end
  assign agent_clk_o = aq;
  // The host oscillator pin is tied low when the board is an agent.
  assign host_clk_o = agent_mode_i ? 1'h0 : hq;
endmodule : pci_clock_source
`default_nettype wire

/* File: dv/clock_ratio_chk.sv */
`timescale 1ns/1ns
`default_nettype none
// Port-level checker for the clock ratio block.
module clock_ratio_chk (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic host_mode_strap_i,
  input wire logic input_halving_strap_i,
  input wire logic [31:0] reset_config_word_low_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic sync_clock_o,
  input wire logic [2:0] bus_clock_outputs_o,
  input wire logic csb_tick_o,
  input wire logic core_tick_o,
  input wire logic memory_bus_clock_o,
  input wire logic memory_bus_clock_n_o,
  input wire logic memory_data_tick_o,
  input wire logic [3:0] csb_ratio_o,
  input wire logic [2:0] core_halves_o,
  input wire logic core_bypass_o,
  input wire logic config_error_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  logic [3:0] mult; // System multiplier field of the strap word.
  assign mult = reset_config_word_low_i[7:4];
  property p_ready;
    psel_i && penable_i && !pready_o |=> pready_o;
  endproperty
  a_ready: assert property (p_ready) else $error("apb answer late");
  property p_out;
    |bus_clock_outputs_o |-> $past(sync_clock_o);
  endproperty
  a_out: assert property (p_out) else $error("bus clock w/o sync");
  property p_pair;
    memory_bus_clock_n_o == !memory_bus_clock_o;
  endproperty
  a_pair: assert property (p_pair) else $error("memory pair broken");
  property p_mtick;
    memory_data_tick_o && !reset_config_word_low_i[1] |=> !memory_data_tick_o;
  endproperty
  a_mtick: assert property (p_mtick) else $error("memory rate wrong");
  property p_csb;
    csb_tick_o |=> !csb_tick_o ##1 csb_tick_o;
  endproperty
  a_csb: assert property (p_csb) else $error("csb tick irregular");
  property p_byp;
    core_bypass_o |-> core_halves_o == 3'h2 && mult >= 4'h0
      && reset_config_word_low_i[12:9] == 4'h0;
  endproperty
  a_byp: assert property (p_byp) else $error("bypass wrong");
  property p_ratio;
    csb_ratio_o != 4'h0 && !config_error_o |->
      csb_ratio_o == (input_halving_strap_i ? mult : {mult[2:0], 1'h0});
  endproperty
  a_ratio: assert property (p_ratio) else $error("csb ratio wrong");
  property p_halves;
    csb_ratio_o != 4'h0 && !core_bypass_o && !config_error_o |->
      core_halves_o == reset_config_word_low_i[10:8];
  endproperty
  a_halves: assert property (p_halves) else $error("core ratio wrong");
  property p_agent;
    !host_mode_strap_i |-> !sync_clock_o;
  endproperty
  a_agent: assert property (p_agent) else $error("sync out in agent");
  property p_core;
    core_tick_o == csb_tick_o;
  endproperty
  a_core: assert property (p_core) else $error("core tick off csb");
  property p_memclk;
    memory_data_tick_o == $changed(memory_bus_clock_o);
  endproperty
  a_memclk: assert property (p_memclk) else $error("memory clock rate");
endmodule : clock_ratio_chk
bind clock_ratio_generation clock_ratio_chk u_chk (.sys_clk_i, .rst_i,
  .host_mode_strap_i, .input_halving_strap_i, .reset_config_word_low_i,
  .psel_i, .penable_i, .pready_o, .sync_clock_o, .bus_clock_outputs_o,
  .csb_tick_o, .core_tick_o, .memory_bus_clock_o, .memory_bus_clock_n_o,
  .memory_data_tick_o, .csb_ratio_o, .core_halves_o, .core_bypass_o,
  .config_error_o);
`default_nettype wire

/* File: dv/clock_ratio_generation_tb.sv */
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the clock ratio block.
module clock_ratio_generation_tb;
  localparam int HH = 3;
  localparam int AH = 5;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic host_mode = 1'h1;
  logic halving = 1'h0;
  logic [31:0] word = 32'h0;
  logic [7:0] paddr = 8'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, primary, sync, csb_tick, core_bypass, cfg_err;
  logic mem_tick, host_clk, agent_clk;
  logic [2:0] bus_out, core_halves;
  logic [1:0] local_clk;
  logic [4:0] unit_en;
  logic [3:0] csb_ratio;
  int bad_count = 0;
  int check_count = 0;
  pci_clock_source #(.HOST_HALF(HH), .AGENT_HALF(AH)) u_src (
    .sys_clk_i(sys_clk), .agent_mode_i(!host_mode),
    .host_clk_o(host_clk), .agent_clk_o(agent_clk));
  clock_ratio_generation uut (.sys_clk_i(sys_clk), .rst_i(rst),
    .host_input_clock_i(host_clk), .agent_clock_i(agent_clk),
    .host_mode_strap_i(host_mode), .input_halving_strap_i(halving),
    .reset_config_word_low_i(word), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .primary_clock_o(primary), .sync_clock_o(sync),
    .bus_clock_outputs_o(bus_out), .csb_tick_o(csb_tick), .core_tick_o(),
    .memory_bus_clock_o(), .memory_bus_clock_n_o(),
    .memory_data_tick_o(mem_tick), .local_bus_clock_out_o(local_clk),
    .unit_clock_en_o(unit_en), .csb_ratio_o(csb_ratio),
    .core_halves_o(core_halves), .core_bypass_o(core_bypass),
    .config_error_o(cfg_err));
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic summarize;
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  // Counts within one cycle of the target pass, since phase is free.
  task automatic near(string nm, int c, int e);
    check(nm, (c - e) inside {[-1:1]} ? e : c, e);
  endtask : near
  // Builds a strap word: core code k, multiplier, memory and local bits.
  function automatic logic [31:0] w(logic [3:0] m, logic [2:0] k,
                                    logic mem, logic lb);
    return {17'h0, 2'h1, 2'h0, k, m, 2'h0, mem, lb};
  endfunction : w
  // Applies straps under a 20-cycle reset and waits for the clocks to run.
  task automatic boot(logic host, logic halve, logic [31:0] cfg);
    int n;
    rst <= 1'h1;
    host_mode <= host;
    halving <= halve;
    word <= cfg;
    repeat (20) @(posedge sys_clk);
    rst <= 1'h0;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (csb_tick !== 1'h1 && n < 80);
    if (n == 80)
    begin
      bad_count++;
      summarize();
    end
  endtask : boot
  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (n == 20)
    begin
      bad_count++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  function automatic logic probe(int s);
    case (s)
      0: return primary;
      1: return sync;
      2: return bus_out[0];
      3: return bus_out[1];
      4: return local_clk[0];
      5: return mem_tick;
      11: return bus_out[2];
      12: return local_clk[1];
      default: return unit_en[s - 6];
    endcase
  endfunction : probe
  // Counts rising edges, or high cycles when edges is low.
  task automatic count(int s, int cyc, logic edges, output int c);
    logic prev;
    c = 0;
    prev = probe(s);
    repeat (cyc)
    begin
      @(posedge sys_clk);
      if (probe(s) === 1'h1 && (!edges || prev === 1'h0)) c++;
      prev = probe(s);
    end
  endtask : count
  task automatic t_regs;
    logic [31:0] d;
    logic e;
    boot(1'h1, 1'h0, w(4'h4, 3'h2, 1'h1, 1'h1));
    apb(1'h0, clock_ratio_pkg::OCC_OFFSET, 32'h0, d, e);
    check("occ", d, 32'(clock_ratio_pkg::OCC_RESET));
    apb(1'h0, clock_ratio_pkg::LBC_OFFSET, 32'h0, d, e);
    check("lbc", d, 32'(clock_ratio_pkg::LBC_RESET));
    apb(1'h0, clock_ratio_pkg::UCC_OFFSET, 32'h0, d, e);
    check("ucc", d, 32'(clock_ratio_pkg::UCC_RESET));
    apb(1'h1, clock_ratio_pkg::CFG_OFFSET, 32'hFFFFFFFF, d, e);
    check("cfg_wr", 32'(e), 32'h0);
    apb(1'h0, 8'h10, 32'h0, d, e);
    check("unmap_err", 32'(e), 32'h1);
    check("unmap_data", d, 32'h0);
  endtask : t_regs
  task automatic t_cfg;
    logic [31:0] d;
    logic e;
    int c;
    int m;
    logic bad;
    for (int n = 0; n < 8; n++)
    begin
      m = (n == 0) ? 4 : n;
      bad = (n == 1 || n == 7);
      boot(1'h1, n[1], w(4'(m), n == 0 ? 3'h1 : 3'(n), n[0], 1'h1));
      check("cfg_err", 32'(cfg_err), 32'(bad));
      if (!bad) check("ratio", 32'(csb_ratio), (n[1] ? 1 : 2) * m);
      if (!bad) check("halves", 32'(core_halves), n < 2 ? 2 : n);
      check("bypass", 32'(core_bypass), 32'(n < 2));
      apb(1'h0, clock_ratio_pkg::CFG_OFFSET, 32'h0, d, e);
      check("cfg_system_multiplier_field", 32'(d[10:7]), m);
      count(5, 40, 1'h0, c);
      check("mem_rate", c, n[0] ? 40 : 20);
    end
  endtask : t_cfg
  task automatic t_clk;
    logic [31:0] d;
    logic e;
    int c;
    boot(1'h1, 1'h0, w(4'h4, 3'h2, 1'h1, 1'h1));
    count(0, 240, 1'h1, c);
    near("host_prim", c, 240 / (2 * HH));
    count(1, 240, 1'h1, c);
    near("sync_half", c, 240 / (4 * HH));
    apb(1'h1, clock_ratio_pkg::OCC_OFFSET, 32'h5, d, e);
    count(3, 240, 1'h1, c);
    check("out1_off", c, 0);
    count(2, 240, 1'h1, c);
    near("out0_on", c, 240 / (4 * HH));
    count(11, 240, 1'h1, c);
    near("out2_on", c, 240 / (4 * HH));
    boot(1'h1, 1'h1, w(4'h4, 3'h2, 1'h1, 1'h1));
    count(1, 240, 1'h1, c);
    near("sync_full", c, 240 / (2 * HH));
    boot(1'h0, 1'h0, w(4'h4, 3'h2, 1'h1, 1'h1));
    count(0, 240, 1'h1, c);
    near("agent_prim", c, 240 / (2 * AH));
    count(1, 240, 1'h1, c);
    check("agent_sync", c, 0);
  endtask : t_clk
  task automatic t_units;
    logic [31:0] d;
    logic e;
    int c;
    int exp [5] = '{0, 30, 15, 10, 30};
    apb(1'h1, clock_ratio_pkg::UCC_OFFSET, 32'h3E4, d, e);
    apb(1'h0, clock_ratio_pkg::UCC_OFFSET, 32'h0, d, e);
    check("ucc_rb", d, 32'h1E4);
    for (int u = 0; u < 5; u++)
    begin
      count(6 + u, 60, 1'h0, c);
      near("unit", c, exp[u]);
    end
  endtask : t_units
  task automatic t_local;
    logic [31:0] d;
    logic e;
    int c;
    int dv [3] = '{2, 4, 8};
    for (int lb = 0; lb < 2; lb++)
    begin
      boot(1'h1, 1'h0, w(4'h4, 3'h2, 1'h0, 1'(lb)));
      for (int i = 0; i < 3; i++)
      begin
        apb(1'h1, clock_ratio_pkg::LBC_OFFSET, 32'(dv[i]), d, e);
        // The old divider finishes its half period before the new one runs.
        repeat (16) @(posedge sys_clk);
        count(4 + 8 * lb, 96, 1'h1, c);
        near("local_bus_clock_out", c, 96 / (dv[i] * (2 - lb)));
      end
    end
  endtask : t_local
  initial
  begin
    t_regs();
    t_cfg();
    t_clk();
    t_units();
    t_local();
    summarize();
  end
endmodule : clock_ratio_generation_tb
`default_nettype wire
